// file: bench/sdma_master_model.sv
// sdma_master_model.sv: external debug master driving the serial link
// assumes mclk at 50 MHz; one link period is eight mclk cycles
`timescale 1ns/1ps
`default_nettype none
module sdma_master_model (
    input  wire logic mclk,
    input  wire logic link_sdo,
    output var  logic link_clk,
    output var  logic link_sel_b,
    output var  logic link_sdi
);
    logic [15:0] tx [0:3];
    logic [15:0] rx [0:3];
    // clock idles low, select idles high
    initial begin
        link_clk = 1'b0;
        link_sel_b = 1'b1;
        link_sdi = 1'b0;
    end
    task automatic tick(input logic c);
        link_clk <= c;
        repeat (4) @(posedge mclk);
    endtask
    // one transaction: command, address, then nw words
    task automatic frame(input logic [7:0] cmd, input logic [15:0] addr, input int nw,
                         input int nrst = 2);
        logic [87:0] bits;
        bits = {cmd, addr, tx[0], tx[1], tx[2], tx[3]};
        // select high two clocks, fewer only when a test wants a refusal
        repeat (nrst) begin
            tick(1'b1);
            tick(1'b0);
        end
        link_sel_b <= 1'b0;
        for (int i = 0; i < 24 + 16 * nw; i++) begin
            link_sdi <= bits[87 - i];
            tick(1'b0);
            tick(1'b1);
            if (i >= 24)
                rx[(i - 24) / 16] = {rx[(i - 24) / 16][14:0], link_sdo};
        end
        tick(1'b0);
        link_sdi <= ~link_sdi;
        link_sel_b <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
endmodule // sdma_master_model
`default_nettype wire

// file: bench/sdma_slave_properties.sv
// sdma_slave_properties.sv: port timing checks for the serial debug slave
// assumes one mclk domain with active-low rst_b
`timescale 1ns/1ps
`default_nettype none
module sdma_slave_properties (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        link_clk,
    input wire logic        link_sel_b,
    input wire logic        link_sdo,
    input wire logic        link_sdo_oe,
    input wire logic        cpu_stopped,
    input wire logic        mem_wr_q,
    input wire logic        mem_rd_q,
    input wire logic [15:0] mem_addr_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [15:0] prev_q;
    logic        seen_q;
    logic [3:0]  fall_q;
    // last strobe address in this frame, cycles since link clock fell
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 16'h0000;
            seen_q <= 1'b0;
            fall_q <= 4'hf;
        end else begin
            prev_q <= (mem_wr_q || mem_rd_q) ? mem_addr_q : prev_q;
            seen_q <= !link_sel_b && (seen_q || mem_wr_q || mem_rd_q);
            fall_q <= $fell(link_clk) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hf};
        end
    end
    sequence s_deselected;
        (link_sel_b && $stable(cpu_stopped)) [*8];
    endsequence
    sequence s_quiet;
        !mem_wr_q && !mem_rd_q;
    endsequence
    a_idle_level:
    assert property (s_deselected |-> link_sdo == cpu_stopped) else $error("idle level wrong");
    a_pin_driven:
    assert property (link_sdo_oe) else $error("serial out not driven");
    a_sdo_on_fall:
    assert property ($changed(link_sdo) && !link_sel_b && $past(link_sel_b, 8) == 1'b0
        |-> fall_q <= 4'h6) else $error("serial out moved off a falling edge");
    a_one_strobe:
    assert property (!(mem_wr_q && mem_rd_q)) else $error("read and write together");
    a_word_gap:
    assert property (mem_wr_q || mem_rd_q |=> s_quiet [*8]) else $error("strobes too close");
    a_wr_step:
    assert property (mem_wr_q && seen_q |-> mem_addr_q == prev_q + 16'h0001)
        else $error("write address not incremented");
    a_rd_step:
    assert property (mem_rd_q && seen_q |-> mem_addr_q == prev_q + 16'h0001)
        else $error("read address not incremented");
    a_strobe_framed:
    assert property (mem_wr_q || mem_rd_q |-> $past(link_sel_b, 3) == 1'b0)
        else $error("strobe outside a transaction");
endmodule // sdma_slave_properties
bind sdma_slave sdma_slave_properties sdma_slave_properties_inst (
    .mclk(mclk), .rst_b(rst_b), .link_clk(link_clk), .link_sel_b(link_sel_b),
    .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe), .cpu_stopped(cpu_stopped),
    .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q)
);
`default_nettype wire

// file: bench/sdma_slave_tb.sv
// sdma_slave_tb.sv: self-checking bench for the serial debug slave
// assumes the master model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module sdma_slave_tb;
    logic        mclk, rst_b, cpu_stopped, link_clk, link_sel_b, link_sdi;
    logic        link_sdo, link_sdo_oe, mem_wr_q, mem_rd_q;
    logic [15:0] mem_addr_q, mem_wdata_q;
    logic [15:0] mem_rdata = 16'h0000;
    logic [15:0] mem [0:255];
    int          err_count = 0;
    int          tests_run = 0;
    int          wr_seen = 0;
    // 50 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    sdma_slave sdma_slave_inst (
        .mclk(mclk), .rst_b(rst_b), .link_clk(link_clk), .link_sel_b(link_sel_b),
        .link_sdi(link_sdi), .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe),
        .cpu_stopped(cpu_stopped), .mem_wr_q(mem_wr_q), .mem_rd_q(mem_rd_q),
        .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata)
    );
    sdma_master_model sdma_master_model_inst (
        .mclk(mclk), .link_sdo(link_sdo), .link_clk(link_clk),
        .link_sel_b(link_sel_b), .link_sdi(link_sdi)
    );
    // memory behind the port, read data one cycle after the address
    always @(posedge mclk) begin
        if (mem_wr_q) begin
            mem[mem_addr_q[7:0]] <= mem_wdata_q;
            wr_seen <= wr_seen + 1;
        end
        mem_rdata <= mem[mem_addr_q[7:0]];
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // two words across a low-byte carry
    task automatic t_write;
        int w0;
        w0 = wr_seen;
        sdma_master_model_inst.tx[0] = 16'hc3a5;
        sdma_master_model_inst.tx[1] = 16'h5a3c;
        sdma_master_model_inst.frame(8'h02, 16'h12ff, 2);
        check("write count", 16'(w0 + 2), 16'(wr_seen));
        check("first word", 16'hc3a5, mem[8'hff]);
        check("second word", 16'h5a3c, mem[8'h00]);
    endtask
    // check word then two consecutive words
    task automatic t_read;
        sdma_master_model_inst.frame(8'h03, 16'h12ff, 3);
        check("check word", 16'h0312, sdma_master_model_inst.rx[0]);
        check("read word", 16'hc3a5, sdma_master_model_inst.rx[1]);
        check("next word", 16'h5a3c, sdma_master_model_inst.rx[2]);
    endtask
    // commands near the valid patterns store nothing
    task automatic t_unknown;
        logic [7:0] cmds [0:2] = '{8'h00, 8'h12, 8'h83};
        int w0;
        w0 = wr_seen;
        sdma_master_model_inst.tx[0] = 16'hffff;
        foreach (cmds[i])
            sdma_master_model_inst.frame(cmds[i], 16'h12ff, 1);
        check("ignored writes", 16'(w0), 16'(wr_seen));
        check("word kept", 16'hc3a5, mem[8'hff]);
    endtask
    // select falls without reset clocks: whole frame refused
    task automatic t_unarmed;
        int w0;
        w0 = wr_seen;
        sdma_master_model_inst.tx[0] = 16'h0f0f;
        sdma_master_model_inst.frame(8'h02, 16'h12ff, 1, 0);
        check("unarmed writes", 16'(w0), 16'(wr_seen));
        check("unarmed word kept", 16'hc3a5, mem[8'hff]);
    endtask
    // deselected output follows processor state
    task automatic t_idle;
        cpu_stopped <= 1'b1;
        repeat (10) @(posedge mclk);
        check("stopped level", 16'h0001, {15'h0, link_sdo});
        cpu_stopped <= 1'b0;
        repeat (10) @(posedge mclk);
        check("running level", 16'h0000, {15'h0, link_sdo});
        check("drive enable", 16'h0001, {15'h0, link_sdo_oe});
    endtask
    task automatic give_verdict;
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // reset, scenarios, verdict
    initial begin
        rst_b = 1'b0;
        cpu_stopped = 1'b0;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (6) @(posedge mclk);
        t_write();
        t_read();
        t_unknown();
        t_unarmed();
        t_idle();
        give_verdict();
    end
    // watchdog far beyond the few thousand cycles needed
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end
endmodule // sdma_slave_tb
`default_nettype wire

// file: design/sdma_slave.v
// sdma_slave.v: serial debug slave giving an external master word access to memory
// assumes mclk at 50 MHz, a link clock well below it, and a memory port that takes
// a one-cycle read or write strobe and returns read data on the next cycle
//
// Functional notes
// - after select falls, eight bits form the command field
// - next sixteen bits form the word address
// - then sixteen-bit data words move in for writes, out for reads
// - serial input sampled on each link clock rising edge
// - serial output changes on link clock falling edge
// - each further sixteen clocks moves one more word, address auto-increments
// - write command 00000010 stores next sixteen input bits at address
// - each further write word stores at incremented address until deselect
// - read command 00000011 returns check word then addressed word
// - check word is command in upper byte, address high byte lower
// - read continues with next consecutive word every sixteen clocks
// - deselected output driven: low while running, high while processor stopped
`timescale 1ns/1ps
`default_nettype none
`include "sdma_defs.vh"

module sdma_slave (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        link_clk,
    input  wire        link_sel_b,
    input  wire        link_sdi,
    output wire        link_sdo,
    output wire        link_sdo_oe,
    input  wire        cpu_stopped,
    output reg         mem_wr_q,
    output reg         mem_rd_q,
    output reg  [15:0] mem_addr_q,
    output reg  [15:0] mem_wdata_q,
    input  wire [15:0] mem_rdata
);

    // transaction phases
    localparam ST_IDLE = 3'h0;
    localparam ST_CMD  = 3'h1;
    localparam ST_ADDR = 3'h2;
    localparam ST_WR   = 3'h3;
    localparam ST_RD   = 3'h4;
    localparam ST_SKIP = 3'h5;

    reg        rs1_q;
    reg        rs2_q;
    wire       rst_i_b;
    wire       clk_s;
    wire       sel_s_b;
    wire       sdi_s;
    wire       cpu_s;
    reg        clk_d1_q;
    reg  [2:0] st_q;
    reg  [4:0] cnt_q;
    reg  [1:0] hi_cnt_q;
    reg        armed_q;
    reg  [7:0] cmd_q;
    reg [15:0] shin_q;
    reg [15:0] shout_q;
    reg        sdo_q;
    reg        first_q;
    wire       rise;
    wire       fall;
    wire [15:0] shin_nx;

    // reset release through two flops
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign rst_i_b = rs2_q;

    // pins from outside the clock domain
    sdma_sync #(.RST_VAL(1'b0)) u_sync_clk (
        .clk   (mclk),
        .rst_b (rst_i_b),
        .d     (link_clk),
        .q     (clk_s)
    );
    sdma_sync #(.RST_VAL(1'b1)) u_sync_sel (
        .clk   (mclk),
        .rst_b (rst_i_b),
        .d     (link_sel_b),
        .q     (sel_s_b)
    );
    sdma_sync #(.RST_VAL(1'b0)) u_sync_sdi (
        .clk   (mclk),
        .rst_b (rst_i_b),
        .d     (link_sdi),
        .q     (sdi_s)
    );
    sdma_sync #(.RST_VAL(1'b0)) u_sync_cpu (
        .clk   (mclk),
        .rst_b (rst_i_b),
        .d     (cpu_stopped),
        .q     (cpu_s)
    );

    // link clock edge detection
    always @(posedge mclk or negedge rst_i_b) begin
        if (!rst_i_b) begin
            clk_d1_q <= 1'b0;
        end else begin
            clk_d1_q <= clk_s;
        end
    end
    assign rise = clk_s & ~clk_d1_q;
    assign fall = ~clk_s & clk_d1_q;

    assign shin_nx = {shin_q[14:0], sdi_s};

    // main sequencer
    always @(posedge mclk or negedge rst_i_b) begin
        if (!rst_i_b) begin
            st_q        <= ST_IDLE;
            cnt_q       <= 5'h00;
            hi_cnt_q    <= 2'h0;
            armed_q     <= 1'b0;
            cmd_q       <= 8'h00;
            shin_q      <= 16'h0000;
            mem_wr_q    <= 1'b0;
            mem_rd_q    <= 1'b0;
            mem_addr_q  <= 16'h0000;
            mem_wdata_q <= 16'h0000;
            first_q     <= 1'b0;
        end else begin
            mem_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            if (sel_s_b) begin
                // count clocks while deselected to arm
                st_q  <= ST_IDLE;
                cnt_q <= 5'h00;
                first_q <= 1'b0;
                if (rise && hi_cnt_q != `SDMA_RST_CLKS) begin
                    hi_cnt_q <= hi_cnt_q + 2'h1;
                end
                if (hi_cnt_q == `SDMA_RST_CLKS) begin
                    armed_q <= 1'b1;
                end
            end else begin
                hi_cnt_q <= 2'h0;
                case (st_q)
                    ST_IDLE: begin
                        // entry only after a proper reset
                        st_q    <= armed_q ? ST_CMD : ST_SKIP;
                        armed_q <= 1'b0;
                    end
                    ST_CMD: begin
                        if (rise) begin
                            shin_q <= shin_nx;
                            cnt_q  <= cnt_q + 5'h01;
                            if (cnt_q == `SDMA_CMD_LAST) begin
                                cmd_q <= shin_nx[7:0];
                                cnt_q <= 5'h00;
                                st_q  <= ST_ADDR;
                            end
                        end
                    end
                    ST_ADDR: begin
                        if (rise) begin
                            shin_q <= shin_nx;
                            cnt_q  <= cnt_q + 5'h01;
                            if (cnt_q == `SDMA_WORD_LAST) begin
                                mem_addr_q <= shin_nx;
                                cnt_q      <= 5'h00;
                                if (cmd_q == `SDMA_CMD_WRITE) begin
                                    st_q <= ST_WR;
                                end else if (cmd_q == `SDMA_CMD_READ) begin
                                    // fetch first word during check word
                                    st_q     <= ST_RD;
                                    mem_rd_q <= 1'b1;
                                    first_q  <= 1'b1;
                                end else begin
                                    st_q <= ST_SKIP;
                                end
                            end
                        end
                    end
                    ST_WR: begin
                        if (rise) begin
                            shin_q <= shin_nx;
                            cnt_q  <= cnt_q + 5'h01;
                            if (cnt_q == `SDMA_WORD_LAST) begin
                                mem_wr_q    <= 1'b1;
                                mem_wdata_q <= shin_nx;
                                cnt_q       <= 5'h00;
                                first_q     <= 1'b1;
                            end
                        end
                        if (first_q && !mem_wr_q) begin
                            first_q <= 1'b0;
                        end
                        if (mem_wr_q) begin
                            mem_addr_q <= mem_addr_q + 16'h0001;
                        end
                    end
                    ST_RD: begin
                        if (rise) begin
                            cnt_q <= cnt_q + 5'h01;
                            if (cnt_q == `SDMA_WORD_LAST) begin
                                cnt_q <= 5'h00;
                                if (first_q) begin
                                    // check word done, first word already held
                                    first_q <= 1'b0;
                                end else begin
                                    mem_addr_q <= mem_addr_q + 16'h0001;
                                    mem_rd_q   <= 1'b1;
                                end
                            end
                        end
                    end
                    ST_SKIP: begin
                        st_q <= ST_SKIP;
                    end
                    default: begin
                        st_q <= ST_SKIP;
                    end
                endcase
            end
        end
    end

    // read data held one cycle after the strobe
    reg [15:0] rd_hold_q;
    reg        rd_ok_q;
    always @(posedge mclk or negedge rst_i_b) begin
        if (!rst_i_b) begin
            rd_hold_q <= 16'h0000;
            rd_ok_q   <= 1'b0;
        end else begin
            rd_ok_q <= mem_rd_q;
            if (rd_ok_q) begin
                rd_hold_q <= mem_rdata;
            end
        end
    end

    // output shifter, shifts only on link falling edges, output follows cpu_s while deselected
    always @(posedge mclk or negedge rst_i_b) begin
        if (!rst_i_b) begin
            shout_q <= 16'h0000;
            sdo_q   <= 1'b0;
        end else if (sel_s_b) begin
            sdo_q <= cpu_s;
        end else if (st_q == ST_RD && fall) begin
            // shift msb first on falling edge
            if (cnt_q == 5'h00 && first_q) begin
                // check word: command, then address high byte
                sdo_q   <= cmd_q[7];
                shout_q <= {cmd_q[6:0], mem_addr_q[15:8], 1'b0};
            end else if (cnt_q == 5'h00) begin
                sdo_q   <= rd_hold_q[15];
                shout_q <= {rd_hold_q[14:0], 1'b0};
            end else begin
                sdo_q   <= shout_q[15];
                shout_q <= {shout_q[14:0], 1'b0};
            end
        end else if (st_q == ST_ADDR && rise && cnt_q == `SDMA_WORD_LAST) begin
            // clear the shifter ahead of the check word
            shout_q <= 16'h0000;
        end
    end

    assign link_sdo    = sdo_q;
    assign link_sdo_oe = 1'b1;

endmodule // sdma_slave

`default_nettype wire

// file: design/sdma_sync.v
// sdma_sync.v: two flip-flop synchroniser for one level
// assumes a single clock and an active-low async reset on that clock
`timescale 1ns/1ps
`default_nettype none

module sdma_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk,
    input  wire rst_b,
    input  wire d,
    output wire q
);

    reg s1_q;
    reg s2_q;

    // first stage feeds only the second
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q;

endmodule // sdma_sync

`default_nettype wire

// file: pkg/sdma_defs.vh
// sdma_defs.vh: constants for the serial debug memory access slave
// assumes inclusion by the design files only; definitions only
`ifndef SDMA_DEFS_VH
`define SDMA_DEFS_VH

`define SDMA_CMD_W        8
`define SDMA_ADDR_W       16
`define SDMA_DATA_W       16
`define SDMA_CMD_WRITE    8'h02
`define SDMA_CMD_READ     8'h03
`define SDMA_CNT_W        5
`define SDMA_CMD_LAST     5'h07
`define SDMA_WORD_LAST    5'h0f
`define SDMA_RST_CLKS     2'h2

`endif
